// *** ird_rate_divider.sv ***
// register front end and serial clock rate generator of the two-wire interface
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps

// Notes on behaviour
// - own-address register bits 7:1 hold the slave address answered to
// - own-address bit 0 always reads zero regardless of writes
// - after reset the block acts as slave watching for its own address
// - own-address and rate registers are readable and writable at any time
// - rate code: bits 7:6 multiplier, 5:3 prescaler, 2:0 tap point
// - tap codes give clock taps 5..15 and data taps 1..4
// - tap spacing is two to the power of the prescaler field
// - prescaler selects edge-to-first-tap, start-hold and stop-hold bases
// - multiplier codes give 1, 2, 4; code 11 is reserved
// - count from SCL fall to first tap equals mul * the edge-to-first-tap value
// - clock tap sets SCL period, data tap sets SDA hold after SCL fall
// - SCL period = mul * 2 * (edge tap + (clock tap-1)*spacing + 2)
// - SDA hold = mul * (edge tap + (data tap-1)*spacing + 3)
// - start hold = mul * (start base + (clock tap-1)*spacing)
// - stop hold = mul * (stop base + (clock tap-1)*spacing)
module ird_rate_divider
    import ird_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              reset,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [DATA_W-1:0] reg_rdata,
    input  wire logic              gen_enable,
    input  wire logic              master_req,
    output logic      [6:0]        slave_address,
    output logic                   slave_mode,
    output logic                   scl_gen,
    output logic                   scl_fall,
    output logic                   sda_change,
    output ird_timing_s            timing
);

    logic [DATA_W-1:0] own_address_reg_r;
    logic [DATA_W-1:0] rate_divider_reg_r;
    logic [DATA_W-1:0] rate_code_r;
    logic [DATA_W-1:0] rdata_r;
    logic [CNT_W-1:0]  cnt_r;
    logic              scl_r;
    logic              run_r;
    logic              fall_r;
    logic              sda_r;
    logic              slave_r;
    ird_timing_s       timing_r;

    // field decode of the code in use
    wire logic [1:0] rate_multiplier = rate_code_r[MUL_HI:MUL_LO];
    wire logic [2:0] presc_fld       = rate_code_r[PRE_HI:PRE_LO];
    wire logic [2:0] tap_fld         = rate_code_r[TAP_HI:TAP_LO];

    // reserved multiplier code is treated as x1
    wire logic [1:0] mul_shift = (rate_multiplier == MUL_X2) ? 2'h1 :
                                 (rate_multiplier == MUL_X4) ? 2'h2 : 2'h0;

    wire logic [CNT_W-1:0] tap_spacing       = ONE << presc_fld;
    wire logic [CNT_W-1:0] edge_to_first_tap = {8'h00, EDGE_TAP[presc_fld]};
    wire logic [CNT_W-1:0] start_hold_base   = {8'h00, START_BASE[presc_fld]};
    wire logic [CNT_W-1:0] stop_hold_base    = {8'h00, STOP_BASE[presc_fld]};
    wire logic [CNT_W-1:0] clk_span =
        CNT_W'({8'h00, CLK_TAP[tap_fld] - 8'h01} * tap_spacing);
    wire logic [CNT_W-1:0] dat_span =
        CNT_W'({8'h00, DAT_TAP[tap_fld] - 8'h01} * tap_spacing);

    // the multiplier is a power of two, so it is applied as a shift
    wire logic [CNT_W-1:0] first_tap  = edge_to_first_tap << mul_shift;
    wire logic [CNT_W-1:0] scl_half   = first_tap +
                                        ((clk_span + SCL_PAD) << mul_shift);
    wire logic [CNT_W-1:0] scl_period = scl_half << 1;
    wire logic [CNT_W-1:0] sda_hold   = first_tap +
                                        ((dat_span + SDA_PAD) << mul_shift);
    wire logic [CNT_W-1:0] start_hold = (start_hold_base + clk_span) << mul_shift;
    wire logic [CNT_W-1:0] stop_hold  = (stop_hold_base + clk_span) << mul_shift;

    wire logic bit_end   = cnt_r == scl_period - ONE;
    // idle generator has no bit in flight, so a new code loads at once
    wire logic boundary  = !run_r || bit_end;
    wire logic pending   = rate_code_r != rate_divider_reg_r;
    // the count restarts at zero on the fall edge, so the first bit is as long as the rest
    wire logic [CNT_W-1:0] cnt_nxt = (!gen_enable || boundary) ? '0 : cnt_r + ONE;
    wire logic scl_nxt   = gen_enable && !boundary && (cnt_r + ONE >= scl_half);
    wire logic sda_nxt   = gen_enable && !boundary &&
                           (cnt_r + ONE == sda_hold);

    wire logic wr_own  = reg_wr && (reg_addr == OFS_OWN_ADDR);
    wire logic wr_rate = reg_wr && (reg_addr == OFS_RATE_DIV);
    wire logic [DATA_W-1:0] gen_status =
        (DATA_W'(scl_r) << ST_SCL) | (DATA_W'(run_r) << ST_RUN) |
        (DATA_W'(pending) << ST_PENDING) | (DATA_W'(slave_r) << ST_SLAVE);
    wire logic [DATA_W-1:0] rd_mux =
        (reg_addr == OFS_OWN_ADDR) ? (own_address_reg_r & OWN_ADDR_MASK) :
        (reg_addr == OFS_RATE_DIV) ? rate_divider_reg_r :
        (reg_addr == OFS_GEN_STAT) ? gen_status : '0;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            own_address_reg_r  <= OWN_ADDR_RST;
            rate_divider_reg_r <= RATE_DIV_RST;
            rdata_r            <= '0;
        end else begin
            if (wr_own) begin
                own_address_reg_r <= reg_wdata & OWN_ADDR_MASK;
            end
            if (wr_rate) begin
                rate_divider_reg_r <= reg_wdata;
            end
            rdata_r <= reg_rd ? rd_mux : '0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rate_code_r <= RATE_DIV_RST;
            cnt_r       <= '0;
            scl_r       <= 1'b1;
            run_r       <= 1'b0;
            fall_r      <= 1'b0;
            sda_r       <= 1'b0;
            slave_r     <= 1'b1;
            timing_r    <= '0;
        end else begin
            if (boundary) begin
                rate_code_r <= rate_divider_reg_r;
            end
            cnt_r    <= cnt_nxt;
            // scl idles high and falls at the start of each bit
            scl_r    <= gen_enable ? scl_nxt : 1'b1;
            fall_r   <= gen_enable && (!run_r || bit_end);
            run_r    <= gen_enable;
            sda_r    <= sda_nxt;
            slave_r  <= !master_req;
            timing_r <= '{scl_period, sda_hold, start_hold, stop_hold};
        end
    end

    assign reg_rdata     = rdata_r;
    assign slave_address = own_address_reg_r[ADR_HI:ADR_LO];
    assign slave_mode    = slave_r;
    assign scl_gen       = scl_r;
    assign scl_fall      = fall_r;
    assign sda_change    = sda_r;
    assign timing        = timing_r;

endmodule

// *** ird_pkg.sv ***
// package: register map, rate code fields and divider lookup tables
package ird_pkg;

    localparam int DATA_W = 8;
    localparam int ADDR_W = 3;
    localparam int CNT_W  = 16;

    // register indices, one per address
    localparam logic [ADDR_W-1:0] OFS_OWN_ADDR  = 3'h0;
    localparam logic [ADDR_W-1:0] OFS_RATE_DIV  = 3'h1;
    localparam logic [ADDR_W-1:0] OFS_BUS_CTRL  = 3'h2;
    localparam logic [ADDR_W-1:0] OFS_BUS_STAT  = 3'h3;
    localparam logic [ADDR_W-1:0] OFS_DATA_IO   = 3'h4;
    localparam logic [ADDR_W-1:0] OFS_CTRL_EXT  = 3'h5;
    localparam logic [ADDR_W-1:0] OFS_GEN_STAT  = 3'h6;

    localparam logic [DATA_W-1:0] OWN_ADDR_RST  = 8'h00;
    localparam logic [DATA_W-1:0] RATE_DIV_RST  = 8'h00;
    localparam logic [DATA_W-1:0] OWN_ADDR_MASK = 8'hFE;
    localparam int ADR_HI = 7;
    localparam int ADR_LO = 1;

    // rate code field positions
    localparam int MUL_HI = 7;
    localparam int MUL_LO = 6;
    localparam int PRE_HI = 5;
    localparam int PRE_LO = 3;
    localparam int TAP_HI = 2;
    localparam int TAP_LO = 0;

    // generator status bit positions
    localparam int ST_SCL     = 0;
    localparam int ST_RUN     = 1;
    localparam int ST_PENDING = 2;
    localparam int ST_SLAVE   = 3;

    localparam logic [1:0] MUL_X1 = 2'h0;
    localparam logic [1:0] MUL_X2 = 2'h1;
    localparam logic [1:0] MUL_X4 = 2'h2;

    localparam logic [CNT_W-1:0] SCL_PAD = 16'h0002;
    localparam logic [CNT_W-1:0] SDA_PAD = 16'h0003;
    localparam logic [CNT_W-1:0] ONE     = 16'h0001;

    localparam logic [7:0] CLK_TAP [8] = '{8'h05, 8'h06, 8'h07, 8'h08,
                                           8'h09, 8'h0A, 8'h0C, 8'h0F};
    localparam logic [7:0] DAT_TAP [8] = '{8'h01, 8'h01, 8'h02, 8'h02,
                                           8'h03, 8'h03, 8'h04, 8'h04};
    localparam logic [7:0] EDGE_TAP [8] = '{8'h04, 8'h04, 8'h06, 8'h06,
                                            8'h0E, 8'h1E, 8'h3E, 8'h7E};
    localparam logic [7:0] START_BASE [8] = '{8'h02, 8'h02, 8'h02, 8'h06,
                                              8'h0E, 8'h1E, 8'h3E, 8'h7E};
    localparam logic [7:0] STOP_BASE [8] = '{8'h07, 8'h07, 8'h09, 8'h09,
                                             8'h11, 8'h21, 8'h41, 8'h81};

    typedef struct packed {
        logic [CNT_W-1:0] scl_period;
        logic [CNT_W-1:0] sda_hold;
        logic [CNT_W-1:0] start_hold;
        logic [CNT_W-1:0] stop_hold;
    } ird_timing_s;

endpackage

// *** ird_rate_divider_props.sv ***
// concurrent checks on the rate divider ports
`timescale 1ns/1ps
module ird_rate_divider_props
    import ird_pkg::*;
(
    input wire logic              ref_clk,
    input wire logic              reset,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic              reg_rd,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic              gen_enable,
    input wire logic              master_req,
    input wire logic [6:0]        slave_address,
    input wire logic              slave_mode,
    input wire logic              scl_gen,
    input wire logic              scl_fall,
    input wire logic              sda_change,
    input ird_timing_s            timing
);
    // cycles since the last bit start; zero means no reference edge yet
    logic [CNT_W-1:0] gap_r;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    always_ff @(posedge ref_clk)
        if (reset || !gen_enable) gap_r <= '0;
        else if (scl_fall) gap_r <= ONE;
        else if (gap_r != '0) gap_r <= gap_r + ONE;
    property p_rd_idle; !reg_rd |=> reg_rdata == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
    property p_own;
        reg_rd && reg_addr == OFS_OWN_ADDR |=> reg_rdata[7:1] == slave_address;
    endproperty
    a_own: assert property (p_own) else $error("address readback");
    property p_bit0; reg_rd && reg_addr == OFS_OWN_ADDR |=> !reg_rdata[0]; endproperty
    a_bit0: assert property (p_bit0) else $error("address bit 0 set");
    property p_slave; 1'b1 |=> slave_mode == !$past(master_req); endproperty
    a_slave: assert property (p_slave) else $error("slave mode");
    property p_fall; scl_fall |-> !scl_gen && $past(gen_enable); endproperty
    a_fall: assert property (p_fall) else $error("fall pulse");
    property p_period;
        scl_fall && gap_r != '0 && $stable(timing) |-> gap_r == timing.scl_period;
    endproperty
    a_period: assert property (p_period) else $error("bit period");
    property p_sda; sda_change && gap_r != '0 |-> gap_r == timing.sda_hold; endproperty
    a_sda: assert property (p_sda) else $error("data hold");
    property p_half; $rose(scl_gen) && gap_r != '0 |-> gap_r == timing.scl_period >> 1; endproperty
    a_half: assert property (p_half) else $error("clock low time");
    property p_idle; !gen_enable |=> scl_gen && !scl_fall; endproperty
    a_idle: assert property (p_idle) else $error("idle clock");
endmodule

// *** ird_bus_peer.sv ***
// another bus party that claims mastership when asked
`timescale 1ns/1ps
module ird_bus_peer (
    input  wire logic ref_clk,
    input  wire logic reset,
    input  wire logic want,
    output logic      master_req
);
    always_ff @(posedge ref_clk) master_req <= !reset && want;
endmodule

// *** tb_ird_rate_divider.sv ***
// self-checking bench for the rate divider
`timescale 1ns/1ps
module tb_ird_rate_divider;
    import ird_pkg::*;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata, reg_rdata;
    logic [6:0]        slave_address;
    logic              ref_clk, reset, reg_wr, reg_rd, gen_enable, want, master_req;
    logic              slave_mode, scl_gen, scl_fall, sda_change;
    logic [7:0]        c;
    ird_timing_s       timing;
    int miscompares, num_checks, cyc;
    int ct[8] = '{5, 6, 7, 8, 9, 10, 12, 15};
    int dt[8] = '{1, 1, 2, 2, 3, 3, 4, 4};
    int et[8] = '{4, 4, 6, 6, 14, 30, 62, 126};
    int sb[8] = '{2, 2, 2, 6, 14, 30, 62, 126};
    int pb[8] = '{7, 7, 9, 9, 17, 33, 65, 129};
    ird_rate_divider ird_rate_divider_i (
        .ref_clk       (ref_clk),
        .reset         (reset),
        .reg_addr      (reg_addr),
        .reg_wdata     (reg_wdata),
        .reg_wr        (reg_wr),
        .reg_rd        (reg_rd),
        .reg_rdata     (reg_rdata),
        .gen_enable    (gen_enable),
        .master_req    (master_req),
        .slave_address (slave_address),
        .slave_mode    (slave_mode),
        .scl_gen       (scl_gen),
        .scl_fall      (scl_fall),
        .sda_change    (sda_change),
        .timing        (timing)
    );
    ird_bus_peer ird_bus_peer_i (
        .ref_clk    (ref_clk),
        .reset      (reset),
        .want       (want),
        .master_req (master_req)
    );
    function automatic ird_timing_s expect_t(logic [7:0] k);
        int m, s, e, t;
        m = (k[7:6] == 2'h1) ? 2 : (k[7:6] == 2'h2) ? 4 : 1;
        s = 1 << k[5:3];
        e = et[k[5:3]];
        t = (ct[k[2:0]] - 1) * s;
        expect_t.scl_period = 16'(m * 2 * (e + t + 2));
        expect_t.sda_hold   = 16'(m * (e + (dt[k[2:0]] - 1) * s + 3));
        expect_t.start_hold = 16'(m * (sb[k[5:3]] + t));
        expect_t.stop_hold  = 16'(m * (pb[k[5:3]] + t));
    endfunction
    task automatic chk(logic [63:0] got, logic [63:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    task automatic wr(logic [ADDR_W-1:0] a, logic [7:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(logic [ADDR_W-1:0] a, logic [7:0] e);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask
    task automatic test_done;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            test_done();
        end
    end
    initial begin
        {reset, reg_wr, reg_rd, gen_enable, want, reg_addr, reg_wdata} = 16'h8000;
        void'($urandom(32'hCE56));
        repeat (3) @(posedge ref_clk);
        reset <= 1'b0;
        rd(OFS_OWN_ADDR, 8'h00);
        chk(slave_mode, 1'b1);
        for (int i = 0; i < 16; i++) begin
            c = (i == 0) ? 8'hBF : (i == 1) ? 8'h87 : 8'($urandom);
            wr(OFS_OWN_ADDR, c);
            rd(OFS_OWN_ADDR, c & 8'hFE);
            chk(slave_address, c[7:1]);
            wr(OFS_RATE_DIV, c);
            rd(OFS_RATE_DIV, c);
            repeat (2) @(posedge ref_clk);
            #1 chk(timing, expect_t(c));
        end
        for (int a = 2; a < 8; a++) if (a != 6) begin
            wr(3'(a), 8'hFF);
            rd(3'(a), 8'h00);
        end
        rd(OFS_GEN_STAT, 8'((1 << ST_SCL) | (1 << ST_SLAVE)));
        @(posedge ref_clk);
        want <= 1'b1;
        repeat (3) @(posedge ref_clk);
        #1 chk(slave_mode, 1'b0);
        want <= 1'b0;
        wr(OFS_RATE_DIV, 8'h00);
        @(posedge ref_clk);
        gen_enable <= 1'b1;
        @(posedge ref_clk);
        #1 chk({scl_fall, scl_gen}, 2'h2);
        repeat (7) @(posedge ref_clk);
        #1 chk(sda_change, 1'b1);
        repeat (200) @(posedge ref_clk);
        // mid-bit rewrite must wait for the boundary
        wr(OFS_RATE_DIV, 8'h11);
        repeat (2) @(posedge ref_clk);
        #1 chk(timing, expect_t(8'h00));
        repeat (300) @(posedge ref_clk);
        #1 chk(timing, expect_t(8'h11));
        c = {2'h0, 3'($urandom % 3), 3'($urandom)};
        wr(OFS_RATE_DIV, c);
        repeat (400) @(posedge ref_clk);
        gen_enable <= 1'b0;
        #1 chk(timing, expect_t(c));
        repeat (2) @(posedge ref_clk);
        #1 chk(scl_gen, 1'b1);
        test_done();
    end
endmodule
bind ird_rate_divider ird_rate_divider_props ird_rate_divider_props_i (
    .ref_clk       (ref_clk),
    .reset         (reset),
    .reg_addr      (reg_addr),
    .reg_rd        (reg_rd),
    .reg_rdata     (reg_rdata),
    .gen_enable    (gen_enable),
    .master_req    (master_req),
    .slave_address (slave_address),
    .slave_mode    (slave_mode),
    .scl_gen       (scl_gen),
    .scl_fall      (scl_fall),
    .sda_change    (sda_change),
    .timing        (timing)
);
